// [logic/lpe_features.sv]
// per-frame linear prediction efficiency and noise closeness feature tracker
`timescale 1ns/10ps
module lpe_features (
   input logic core_clk,
   input logic rst,
   input logic frame_strobe,
   input logic [31:0] res_energy_0,
   input logic [31:0] res_energy_2,
   input logic [31:0] res_energy_16,
   input logic signed [15:0] frame_energy,
   input logic signed [15:0] noise_level,
   input logic signed [15:0] long_term_min_energy,
   output logic feat_valid,
   output logic frame_dropped,
   output logic frame_ready,
   output logic signed [23:0] low_order_pred_gain,
   output logic signed [23:0] low_order_gain_avg,
   output logic signed [23:0] low_order_dev,
   output logic signed [23:0] low_order_dev_avg,
   output logic signed [23:0] low_order_dev_peak,
   output logic signed [23:0] high_order_pred_gain,
   output logic signed [23:0] high_order_fast_gain,
   output logic signed [23:0] slow_high_order_gain,
   output logic signed [23:0] high_order_spread,
   output logic signed [23:0] high_order_spread_avg,
   output logic signed [23:0] high_order_spread_peak,
   output logic signed [23:0] noise_dist_avg,
   output logic signed [23:0] noise_closeness,
   output logic [15:0] closeness_count,
   output logic signed [23:0] min_energy_distance_avg
);
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_DIVIDE,
      PH_TRACK
   } lpe_phase_t;

   typedef struct packed {
      lpe_phase_t phase;
      logic div_start;
      logic trk_upd;
      logic feat_valid;
      logic dropped;
      logic ready;
      logic [31:0] res0;
      logic [31:0] res2;
      logic [31:0] res16;
      logic signed [15:0] e_frame;
      logic signed [15:0] n_level;
      logic signed [15:0] e_min;
      logic signed [23:0] lo_gain;
      logic signed [23:0] lo_avg;
      logic signed [23:0] lo_dev;
      logic signed [23:0] lo_dev_avg;
      logic signed [23:0] lo_peak;
      logic signed [23:0] hi_gain;
      logic signed [23:0] hi_fast;
      logic signed [23:0] hi_slow;
      logic signed [23:0] hi_spread;
      logic signed [23:0] hi_spread_avg;
      logic signed [23:0] hi_peak;
   } lpe_main_st_t;

   // reset state: everything cleared but the ready flag, so a strobe is taken at once
   localparam lpe_main_st_t ST_RESET = '{phase: PH_IDLE, ready: 1'b1, default: '0};

   lpe_main_st_t st;
   lpe_main_st_t next_st;

   logic lo_done;
   logic hi_done;
   logic [15:0] lo_quot;
   logic [15:0] hi_quot;
   logic signed [23:0] g_lo;
   logic signed [23:0] g_hi;
   logic signed [23:0] lo_avg_n;
   logic signed [23:0] lo_dev_n;
   logic signed [23:0] lo_dev_avg_n;
   logic signed [23:0] hi_fast_n;
   logic signed [23:0] hi_slow_n;
   logic signed [23:0] spread_n;
   logic signed [23:0] spread_avg_n;

   lpe_energy_if eb();

   // both ratios run in parallel; the quotient is unsigned so the low clamp is free
   lpe_div u_lo_div (
      .core_clk(core_clk),
      .rst(rst),
      .start(st.div_start),
      .num(st.res0),
      .den(st.res2),
      .done(lo_done),
      .quot(lo_quot)
   );

   lpe_div u_hi_div (
      .core_clk(core_clk),
      .rst(rst),
      .start(st.div_start),
      .num(st.res2),
      .den(st.res16),
      .done(hi_done),
      .quot(hi_quot)
   );

   lpe_energy_track u_track (
      .core_clk(core_clk),
      .rst(rst),
      .eb(eb.tracker)
   );

   // energies held from the accepted strobe, so the tracker sees one frame only
   assign eb.upd = st.trk_upd;
   assign eb.frame_energy = st.e_frame;
   assign eb.noise_level = st.n_level;
   assign eb.min_energy = st.e_min;

   // widen the Q4.12 quotients into the signed feature format
   assign g_lo = {8'h00, lo_quot};
   assign g_hi = {8'h00, hi_quot};

   // frame sequencer and recursive feature update
   always_comb begin
      next_st = st;
      next_st.div_start = 1'b0;
      next_st.trk_upd = 1'b0;
      next_st.feat_valid = 1'b0;
      next_st.dropped = 1'b0;
      lo_avg_n = lpe_pkg::lpe_lpf(st.lo_avg, g_lo, lpe_pkg::COEF_0P15);
      lo_dev_n = (lo_avg_n > g_lo) ? (lo_avg_n - g_lo) : (g_lo - lo_avg_n);
      lo_dev_avg_n = lpe_pkg::lpe_lpf(st.lo_dev_avg, lo_dev_n,
         (lo_dev_n < st.lo_dev_avg) ? lpe_pkg::COEF_0P1 : lpe_pkg::COEF_0P2);
      hi_fast_n = lpe_pkg::lpe_lpf(st.hi_fast, g_hi,
         (g_hi > st.hi_fast) ? lpe_pkg::COEF_0P2 : lpe_pkg::COEF_0P03);
      hi_slow_n = lpe_pkg::lpe_lpf(st.hi_slow, g_hi, lpe_pkg::COEF_0P02);
      spread_n = hi_fast_n - hi_slow_n;
      spread_avg_n = lpe_pkg::lpe_lpf(st.hi_spread_avg, spread_n,
         (spread_n < st.hi_spread_avg) ? lpe_pkg::COEF_0P02 : lpe_pkg::COEF_0P05);
      case (st.phase)
         PH_IDLE: begin
            if (frame_strobe) begin
               next_st.res0 = res_energy_0;
               next_st.res2 = res_energy_2;
               next_st.res16 = res_energy_16;
               next_st.e_frame = frame_energy;
               next_st.n_level = noise_level;
               next_st.e_min = long_term_min_energy;
               next_st.div_start = 1'b1;
               next_st.phase = PH_DIVIDE;
            end
         end
         PH_DIVIDE: begin
            // comparisons above read the previous frame's held averages
            if (lo_done && hi_done) begin
               next_st.lo_gain = g_lo;
               next_st.hi_gain = g_hi;
               next_st.lo_avg = lo_avg_n;
               next_st.lo_dev = lo_dev_n;
               next_st.lo_dev_avg = lo_dev_avg_n;
               next_st.lo_peak = lpe_pkg::lpe_max(lo_dev_avg_n, lo_dev_n);
               next_st.hi_fast = hi_fast_n;
               next_st.hi_slow = hi_slow_n;
               next_st.hi_spread = spread_n;
               next_st.hi_spread_avg = spread_avg_n;
               next_st.hi_peak = lpe_pkg::lpe_max(spread_avg_n, spread_n);
               next_st.trk_upd = 1'b1;
               next_st.phase = PH_TRACK;
            end
         end
         PH_TRACK: begin
            // tracker registers this edge, so every output is fresh with the valid pulse
            next_st.feat_valid = 1'b1;
            next_st.phase = PH_IDLE;
         end
         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase
      // a strobe during processing is not queued; the host is told with a pulse
      if (frame_strobe && (st.phase != PH_IDLE)) begin
         next_st.dropped = 1'b1;
      end
      next_st.ready = (next_st.phase == PH_IDLE); // registered so the pin has no decode
   end

   // single state register; reset zeroes every average and the phase
   always_ff @(posedge core_clk) begin
      if (rst) st <= ST_RESET;
      else st <= next_st;
   end

   // feature outputs for the noise-update decision logic, all from flops
   assign feat_valid = st.feat_valid;
   assign frame_dropped = st.dropped;
   assign frame_ready = st.ready;
   assign low_order_pred_gain = st.lo_gain;
   assign low_order_gain_avg = st.lo_avg;
   assign low_order_dev = st.lo_dev;
   assign low_order_dev_avg = st.lo_dev_avg;
   assign low_order_dev_peak = st.lo_peak;
   assign high_order_pred_gain = st.hi_gain;
   assign high_order_fast_gain = st.hi_fast;
   assign slow_high_order_gain = st.hi_slow;
   assign high_order_spread = st.hi_spread;
   assign high_order_spread_avg = st.hi_spread_avg;
   assign high_order_spread_peak = st.hi_peak;
   assign noise_dist_avg = eb.noise_dist;
   assign noise_closeness = eb.closeness;
   assign closeness_count = eb.count;
   assign min_energy_distance_avg = eb.min_dist;

   // checks on frame timing and feature relations
   a_lo_gain_range: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (low_order_pred_gain >= lpe_pkg::FEAT_ZERO)
                     && (low_order_pred_gain <= lpe_pkg::GAIN_MAX_S))
      else $error("low-order gain outside clamp");

   a_hi_gain_range: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (high_order_pred_gain >= lpe_pkg::FEAT_ZERO)
                     && (high_order_pred_gain <= lpe_pkg::GAIN_MAX_S))
      else $error("high-order gain outside clamp");

   a_zero_den_sat: assert property (
      @(posedge core_clk) disable iff (rst)
      (frame_ready && frame_strobe && (res_energy_2 == 32'h0))
      |-> ##19 (feat_valid && (low_order_pred_gain == lpe_pkg::GAIN_MAX_S)))
      else $error("zero denominator did not saturate low-order gain");

   a_frame_latency: assert property (
      @(posedge core_clk) disable iff (rst)
      (frame_ready && frame_strobe) |-> !feat_valid [*8] ##1 !feat_valid [*8]
                                        ##1 !feat_valid [*3] ##1 feat_valid)
      else $error("frame result not presented after nineteen cycles");

   a_once_per_frame: assert property (
      @(posedge core_clk) disable iff (rst)
      ($changed(st.lo_avg) || $changed(st.hi_slow) || $changed(closeness_count))
      |-> (st.phase == PH_TRACK) || feat_valid)
      else $error("long-term state moved outside the frame update");

   a_lo_dev_abs: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (low_order_dev == ((low_order_gain_avg > low_order_pred_gain)
                     ? (low_order_gain_avg - low_order_pred_gain)
                     : (low_order_pred_gain - low_order_gain_avg))))
      else $error("low-order deviation is not the absolute difference");

   a_lo_peak_max: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (low_order_dev_peak >= low_order_dev)
                     && (low_order_dev_peak >= low_order_dev_avg)
                     && ((low_order_dev_peak == low_order_dev)
                         || (low_order_dev_peak == low_order_dev_avg)))
      else $error("low-order peak is not the larger value");

   a_spread_diff: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (high_order_spread == (high_order_fast_gain - slow_high_order_gain)))
      else $error("spread differs from fast minus slow");

   a_hi_peak_max: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (high_order_spread_peak >= high_order_spread)
                     && (high_order_spread_peak >= high_order_spread_avg))
      else $error("high-order peak is below one of its inputs");

   a_fast_rise: assert property (
      @(posedge core_clk) disable iff (rst)
      (feat_valid && (high_order_pred_gain > $past(high_order_fast_gain, 2)))
      |-> (high_order_fast_gain >= $past(high_order_fast_gain, 2)))
      else $error("fast high-order average fell on a rising gain");

   a_count_clear: assert property (
      @(posedge core_clk) disable iff (rst)
      (feat_valid && (noise_closeness >= lpe_pkg::CLOSE_FRAC_MIN))
      |-> (closeness_count == 16'h0000))
      else $error("closeness counter not cleared");

   a_count_step: assert property (
      @(posedge core_clk) disable iff (rst)
      (feat_valid && (noise_closeness < lpe_pkg::CLOSE_FRAC_MIN)
       && ($past(closeness_count) != lpe_pkg::CNT_MAX))
      |-> (closeness_count == $past(closeness_count) + lpe_pkg::CNT_ONE))
      else $error("closeness counter did not step by one");

   a_idle_hold: assert property (
      @(posedge core_clk) disable iff (rst)
      (frame_ready && !frame_strobe) |=> $stable(noise_dist_avg) && $stable(low_order_gain_avg))
      else $error("averages moved while idle");

   a_valid_pulse: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |=> !feat_valid)
      else $error("valid held longer than one cycle");

   a_drop_flag: assert property (
      @(posedge core_clk) disable iff (rst)
      (frame_strobe && !frame_ready) |=> frame_dropped)
      else $error("refused strobe not flagged");

   a_ready_valid: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> frame_ready)
      else $error("not ready when features are presented");

   a_hi_peak_pick: assert property (
      @(posedge core_clk) disable iff (rst)
      feat_valid |-> (high_order_spread_peak == high_order_spread)
                     || (high_order_spread_peak == high_order_spread_avg))
      else $error("high-order peak is neither of its inputs");

   a_slow_follow: assert property (
      @(posedge core_clk) disable iff (rst)
      (feat_valid && (high_order_pred_gain >= $past(slow_high_order_gain, 2)))
      |-> (slow_high_order_gain >= $past(slow_high_order_gain, 2)))
      else $error("slow high-order average fell on a higher gain");

   a_reset_clear: assert property (
      @(posedge core_clk)
      rst |=> (closeness_count == 16'h0000) && (noise_closeness == lpe_pkg::FEAT_ZERO)
              && (low_order_gain_avg == lpe_pkg::FEAT_ZERO) && frame_ready && !feat_valid)
      else $error("reset left state behind");
endmodule : lpe_features

// [logic/lpe_pkg.sv]
// shared constants, fixed-point formats and arithmetic helpers for the lp efficiency block
package lpe_pkg;
   // gains are Q4.12, energies in dB are Q8.8, fractions are Q0.16
   localparam int GAIN_FRAC = 12;
   localparam int SAT_SHIFT = 3;
   localparam logic [3:0] DIV_STEPS = 4'hF;
   localparam logic [15:0] GAIN_MAX = 16'h8000;
   localparam logic signed [23:0] GAIN_MAX_S = 24'sh008000;
   localparam logic signed [23:0] FEAT_ZERO = 24'sh000000;
   // recursive average weights as Q0.16 fractions
   localparam logic [15:0] COEF_0P15 = 16'h2666;
   localparam logic [15:0] COEF_0P1 = 16'h199A;
   localparam logic [15:0] COEF_0P2 = 16'h3333;
   localparam logic [15:0] COEF_0P03 = 16'h07AE;
   localparam logic [15:0] COEF_0P02 = 16'h051F;
   localparam logic [15:0] COEF_0P05 = 16'h0CCD;
   localparam logic signed [23:0] UNIT_FRAC = 24'sh010000;
   localparam logic signed [23:0] CLOSE_FRAC_MIN = 24'sh000CCD;
   localparam logic signed [23:0] CLOSE_DB = 24'sh000A00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // one step of prev + alpha * (x - prev), floor rounding
   function automatic logic signed [23:0] lpe_lpf(input logic signed [23:0] prev,
                                                  input logic signed [23:0] x,
                                                  input logic [15:0] alpha);
      logic signed [24:0] diff;
      logic signed [41:0] prod;
      diff = 25'(x) - 25'(prev);
      prod = 42'(diff) * 42'($signed({1'b0, alpha}));
      return prev + prod[39:16];
   endfunction : lpe_lpf

   function automatic logic signed [23:0] lpe_max(input logic signed [23:0] a,
                                                  input logic signed [23:0] b);
      return (a > b) ? a : b;
   endfunction : lpe_max
endpackage : lpe_pkg

// [logic/lpe_energy_if.sv]
// energy inputs and long-term energy features passed between core and tracker
`timescale 1ns/10ps
interface lpe_energy_if;
   logic upd;
   logic signed [15:0] frame_energy;
   logic signed [15:0] noise_level;
   logic signed [15:0] min_energy;
   logic signed [23:0] noise_dist;
   logic signed [23:0] closeness;
   logic signed [23:0] min_dist;
   logic [15:0] count;
   modport feeder(output upd, frame_energy, noise_level, min_energy,
                  input noise_dist, closeness, min_dist, count);
   modport tracker(input upd, frame_energy, noise_level, min_energy,
                   output noise_dist, closeness, min_dist, count);
endinterface : lpe_energy_if

// [logic/lpe_div.sv]
// fixed-latency clamped divider giving num/den in Q4.12, saturating at 8.0
`timescale 1ns/10ps
module lpe_div (
   input logic core_clk,
   input logic rst,
   input logic start,
   input logic [31:0] num,
   input logic [31:0] den,
   output logic done,
   output logic [15:0] quot
);
   typedef struct packed {
      logic busy;
      logic done;
      logic sat;
      logic [3:0] cnt;
      logic [47:0] rem;
      logic [47:0] dsh;
      logic [15:0] q;
   } lpe_div_st_t;

   lpe_div_st_t st;
   lpe_div_st_t next_st;

   // latency is the same on the saturating path so both dividers finish together
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.busy = 1'b1;
         next_st.cnt = lpe_pkg::DIV_STEPS;
         next_st.rem = 48'(num) << lpe_pkg::GAIN_FRAC;
         next_st.dsh = 48'(den) << (lpe_pkg::DIV_STEPS - 4'h1);
         next_st.q = 16'h0000;
         next_st.sat = (den == 32'h0)
            || (48'(num) >= (48'(den) << lpe_pkg::SAT_SHIFT));
      end else if (st.busy) begin
         if (st.rem >= st.dsh) begin
            next_st.rem = st.rem - st.dsh;
            next_st.q = {st.q[14:0], 1'b1};
         end else begin
            next_st.q = {st.q[14:0], 1'b0};
         end
         next_st.dsh = st.dsh >> 1;
         next_st.cnt = st.cnt - 4'h1;
         if (st.cnt == 4'h1) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            if (st.sat) begin
               next_st.q = lpe_pkg::GAIN_MAX; // upper clamp
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign done = st.done;
   assign quot = st.q;
endmodule : lpe_div

// [logic/lpe_energy_track.sv]
// long-term energy distances, closeness fraction and closeness frame counter
`timescale 1ns/10ps
module lpe_energy_track (
   input logic core_clk,
   input logic rst,
   lpe_energy_if.tracker eb
);
   typedef struct packed {
      logic signed [23:0] noise_dist;
      logic signed [23:0] closeness;
      logic signed [23:0] min_dist;
      logic [15:0] count;
   } lpe_trk_st_t;

   lpe_trk_st_t st;
   lpe_trk_st_t next_st;
   logic signed [23:0] d_noise;
   logic signed [23:0] d_min;

   // counter looks at the freshly updated fraction, and sticks at its top
   always_comb begin
      next_st = st;
      d_noise = 24'(eb.frame_energy) - 24'(eb.noise_level);
      d_min = 24'(eb.frame_energy) - 24'(eb.min_energy);
      if (eb.upd) begin
         next_st.noise_dist = lpe_pkg::lpe_lpf(st.noise_dist, d_noise,
            lpe_pkg::COEF_0P03);
         next_st.closeness = lpe_pkg::lpe_lpf(st.closeness,
            (d_noise < lpe_pkg::CLOSE_DB) ? lpe_pkg::UNIT_FRAC : lpe_pkg::FEAT_ZERO,
            lpe_pkg::COEF_0P03);
         if (next_st.closeness >= lpe_pkg::CLOSE_FRAC_MIN) next_st.count = 16'h0000;
         else if (st.count != lpe_pkg::CNT_MAX) next_st.count = st.count + lpe_pkg::CNT_ONE;
         next_st.min_dist = lpe_pkg::lpe_lpf(st.min_dist, d_min, lpe_pkg::COEF_0P03);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign eb.noise_dist = st.noise_dist;
   assign eb.closeness = st.closeness;
   assign eb.min_dist = st.min_dist;
   assign eb.count = st.count;
endmodule : lpe_energy_track

// [tb/lpe_frame_src.sv]
// frame source standing in for the upstream prediction analysis
`timescale 1ns/10ps
module lpe_frame_src (
   input logic core_clk,
   output logic frame_strobe,
   output logic [31:0] res_energy_0,
   output logic [31:0] res_energy_2,
   output logic [31:0] res_energy_16,
   output logic signed [15:0] frame_energy,
   output logic signed [15:0] noise_level,
   output logic signed [15:0] long_term_min_energy
);
   // quiet lines at time zero
   initial begin
      frame_strobe = 1'b0;
      {res_energy_0, res_energy_2, res_energy_16} = '0;
      {frame_energy, noise_level, long_term_min_energy} = '0;
   end

   // one-cycle frame; afterwards the lines are inverted so stale data never looks valid
   task automatic send(input logic [31:0] e0, e2, e16, input logic signed [15:0] fe, nl, lm);
      @(posedge core_clk);
      frame_strobe <= 1'b1;
      res_energy_0 <= e0;
      res_energy_2 <= e2;
      res_energy_16 <= e16;
      frame_energy <= fe;
      noise_level <= nl;
      long_term_min_energy <= lm;
      @(posedge core_clk);
      frame_strobe <= 1'b0;
      res_energy_0 <= ~e0;
      res_energy_2 <= ~e2;
      res_energy_16 <= ~e16;
      frame_energy <= ~fe;
      noise_level <= ~nl;
      long_term_min_energy <= ~lm;
   endtask : send
endmodule : lpe_frame_src

// [tb/lp_efficiency_noise_features_tb_top.sv]
// self-checking bench for the lp efficiency and noise closeness feature tracker
`timescale 1ns/10ps
module lp_efficiency_noise_features_tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic frame_strobe, feat_valid, frame_dropped, frame_ready;
   logic [31:0] res_energy_0, res_energy_2, res_energy_16;
   logic signed [15:0] frame_energy, noise_level, long_term_min_energy;
   logic signed [23:0] low_order_pred_gain, low_order_gain_avg, low_order_dev, low_order_dev_avg;
   logic signed [23:0] low_order_dev_peak, high_order_pred_gain, high_order_fast_gain;
   logic signed [23:0] slow_high_order_gain, high_order_spread, high_order_spread_avg;
   logic signed [23:0] high_order_spread_peak, noise_dist_avg, noise_closeness;
   logic signed [23:0] min_energy_distance_avg;
   logic [15:0] closeness_count, m_cnt;
   logic signed [23:0] m_g1, m_lavg, m_dev, m_davg, m_dpk, m_g2, m_fast, m_slow;
   logic signed [23:0] m_spr, m_savg, m_spk, m_nd, m_cl, m_md;
   logic [31:0] seed = 32'h51;
   int miscompares = 0;
   int check_count = 0;

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   lpe_frame_src lpe_frame_src_inst (.core_clk(core_clk), .frame_strobe(frame_strobe),
      .res_energy_0(res_energy_0), .res_energy_2(res_energy_2), .res_energy_16(res_energy_16),
      .frame_energy(frame_energy), .noise_level(noise_level),
      .long_term_min_energy(long_term_min_energy));

   lpe_features lpe_features_inst (.core_clk(core_clk), .rst(rst), .frame_strobe(frame_strobe),
      .res_energy_0(res_energy_0), .res_energy_2(res_energy_2), .res_energy_16(res_energy_16),
      .frame_energy(frame_energy), .noise_level(noise_level),
      .long_term_min_energy(long_term_min_energy), .feat_valid(feat_valid),
      .frame_dropped(frame_dropped), .frame_ready(frame_ready),
      .low_order_pred_gain(low_order_pred_gain), .low_order_gain_avg(low_order_gain_avg),
      .low_order_dev(low_order_dev), .low_order_dev_avg(low_order_dev_avg),
      .low_order_dev_peak(low_order_dev_peak), .high_order_pred_gain(high_order_pred_gain),
      .high_order_fast_gain(high_order_fast_gain), .slow_high_order_gain(slow_high_order_gain),
      .high_order_spread(high_order_spread), .high_order_spread_avg(high_order_spread_avg),
      .high_order_spread_peak(high_order_spread_peak), .noise_dist_avg(noise_dist_avg),
      .noise_closeness(noise_closeness), .closeness_count(closeness_count),
      .min_energy_distance_avg(min_energy_distance_avg));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // floor rounding, like an arithmetic shift of the product
   function automatic logic signed [23:0] lpf(input logic signed [23:0] p, x,
                                              input logic [15:0] a);
      logic signed [63:0] d;
      d = x;
      d = (d - p) * $signed({48'h0, a});
      return p + 24'(d >>> 16);
   endfunction : lpf

   // a zero denominator saturates like an oversized ratio
   function automatic logic signed [23:0] gain(input logic [31:0] n, d);
      logic [63:0] q;
      if (d == 32'h0 || 64'(n) >= 64'(d) * 64'h8)
         return 24'sh008000;
      q = (64'(n) << 12) / 64'(d);
      return 24'(q);
   endfunction : gain

   function automatic logic signed [23:0] mx(input logic signed [23:0] a, b);
      return (a > b) ? a : b;
   endfunction : mx

   // advance the reference by one accepted frame; comparisons use held averages
   task automatic step(input logic [31:0] e0, e2, e16, input logic signed [15:0] fe, nl, lm);
      logic signed [23:0] d, t;
      d = 24'(fe) - 24'(nl);
      m_g1 = gain(e0, e2);
      m_lavg = lpf(m_lavg, m_g1, 16'h2666);
      t = m_lavg - m_g1;
      m_dev = (t < 0) ? -t : t;
      m_davg = lpf(m_davg, m_dev, (m_dev < m_davg) ? 16'h199A : 16'h3333);
      m_dpk = mx(m_davg, m_dev);
      m_g2 = gain(e2, e16);
      m_fast = lpf(m_fast, m_g2, (m_g2 > m_fast) ? 16'h3333 : 16'h07AE);
      m_slow = lpf(m_slow, m_g2, 16'h051F);
      m_spr = m_fast - m_slow;
      m_savg = lpf(m_savg, m_spr, (m_spr < m_savg) ? 16'h051F : 16'h0CCD);
      m_spk = mx(m_savg, m_spr);
      m_nd = lpf(m_nd, d, 16'h07AE);
      m_cl = lpf(m_cl, (d < 24'sh000A00) ? 24'sh010000 : 24'sh000000, 16'h07AE);
      m_cnt = (m_cl >= 24'sh000CCD) ? 16'h0000 :
         ((m_cnt == 16'hFFFF) ? m_cnt : m_cnt + 16'h0001);
      m_md = lpf(m_md, 24'(fe) - 24'(long_term_min_energy_hold(lm)), 16'h07AE);
   endtask : step

   function automatic logic signed [15:0] long_term_min_energy_hold(input logic signed [15:0] v);
      return v;
   endfunction : long_term_min_energy_hold

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic compare_all();
      chk(low_order_pred_gain, m_g1);
      chk(low_order_gain_avg, m_lavg);
      chk(low_order_dev, m_dev);
      chk(low_order_dev_avg, m_davg);
      chk(low_order_dev_peak, m_dpk);
      chk(high_order_pred_gain, m_g2);
      chk(high_order_fast_gain, m_fast);
      chk(slow_high_order_gain, m_slow);
      chk(high_order_spread, m_spr);
      chk(high_order_spread_avg, m_savg);
      chk(high_order_spread_peak, m_spk);
      chk(noise_dist_avg, m_nd);
      chk(noise_closeness, m_cl);
      chk({8'h00, closeness_count}, {8'h00, m_cnt});
      chk(min_energy_distance_avg, m_md);
   endtask : compare_all

   // reset clears every average and the counter
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      {m_g1, m_lavg, m_dev, m_davg, m_dpk, m_g2, m_fast, m_slow, m_spr, m_savg, m_spk} = '0;
      {m_nd, m_cl, m_md, m_cnt} = '0;
      #1;
      chk({23'h0, frame_ready}, 24'h1);
      compare_all();
   endtask : do_reset

   // one frame; optionally a second strobe lands while busy and must be dropped
   task automatic run_frame(input logic [31:0] e0, e2, e16,
                            input logic signed [15:0] fe, nl, lm, input logic drop);
      int n;
      logic dropped;
      n = 1;
      dropped = 1'b0;
      lpe_frame_src_inst.send(e0, e2, e16, fe, nl, lm);
      #1;
      chk({23'h0, frame_ready}, 24'h0);
      while (feat_valid !== 1'b1 && n < 40) begin
         if (drop && n == 5) begin
            lpe_frame_src_inst.send(~e0, e16, e2, lm, fe, nl);
            n = n + 2;
         end else begin
            @(posedge core_clk);
            n = n + 1;
         end
         #1;
         dropped = dropped | (frame_dropped === 1'b1);
      end
      chk(24'(n), 24'h13);
      chk({23'h0, dropped}, {23'h0, drop});
      step(e0, e2, e16, fe, nl, lm);
      compare_all();
   endtask : run_frame

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   // corner frames first, then random traffic with drops and a reset in mid-run
   initial begin
      logic [31:0] a, b, c, r;
      logic signed [15:0] f;
      do_reset();
      run_frame(32'h0, 32'h0, 32'h0, 16'sh0000, 16'sh0000, 16'sh0000, 1'b0);
      run_frame(32'h320, 32'h64, 32'h0C, 16'sh1000, 16'sh0700, 16'sh0800, 1'b0);
      run_frame(32'h0, 32'h5, 32'hFFFFFFFF, 16'sh8000, 16'sh7FFF, 16'sh7FFF, 1'b0);
      run_frame(32'hFFFFFFFF, 32'h3, 32'h1, 16'sh0A00, 16'sh0000, 16'shF000, 1'b1);
      for (int i = 0; i < 40; i++) begin
         r = xs();
         b = r >> (r[3:0] + 4);
         a = b * (xs() % 10);
         c = b / (xs() % 12 + 1);
         f = 16'(xs());
         run_frame(a, b, c, f, f - 16'(xs() % 5000), f - 16'(xs() % 8192), i % 13 == 7);
         if (i == 25)
            do_reset();
      end
      close_out();
   end

   // watchdog: about ten times the expected run
   initial begin
      #50000;
      miscompares++;
      close_out();
   end
endmodule : lp_efficiency_noise_features_tb_top
